//--- logic/scs_clock_select.v
// System clock source select with APB register access
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_clock_select #(
	parameter LOCK_CYC = `SCS_LOCK_CYC,
	parameter STABLE_CYC = `SCS_STABLE_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [1:0] fosc_cfg,
	input wire clock_output_enable_n,
	input wire pll_cfg_en,
	input wire clock_input_pin,
	input wire timer_osc_clk,
	input wire internal_16m_source,
	input wire internal_500k_source,
	input wire internal_31k_source,
	output reg sysclk_out,
	output reg clock_output_pin,
	output reg clock_output_oe,
	output reg clock_input_pin_is_gpio,
	output reg hf_enable,
	output reg mf_enable,
	output reg lf_enable,
	output reg pll_enable,
	output reg fast_start_en,
	output reg [5:0] tune_out,
	output reg osc_startup_timer_en
);
// ****************************************
// Pin and source synchronisers
// ****************************************
// Sources are sampled twice before any use; the selected clock is a
// pclk-sampled replica, so it can never be shorter than one pclk period
reg [4:0] src_m_r;
reg [4:0] src_s_r;
reg [1:0] fosc_m_r;
reg [1:0] fosc_s_r;
reg coe_m_r;
reg coe_s_r;
reg plc_m_r;
reg plc_s_r;
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		src_m_r <= 5'h00;
		src_s_r <= 5'h00;
		fosc_m_r <= 2'h0;
		fosc_s_r <= 2'h0;
		coe_m_r <= 1'b1;
		coe_s_r <= 1'b1;
		plc_m_r <= 1'b0;
		plc_s_r <= 1'b0;
	end
	else
	begin
		src_m_r <= {internal_31k_source, internal_500k_source, internal_16m_source,
			timer_osc_clk, clock_input_pin};
		src_s_r <= src_m_r;
		fosc_m_r <= fosc_cfg;
		fosc_s_r <= fosc_m_r;
		coe_m_r <= clock_output_enable_n;
		coe_s_r <= coe_m_r;
		plc_m_r <= pll_cfg_en;
		plc_s_r <= plc_m_r;
	end
end
// ****************************************
// Registers
// ****************************************
reg [1:0] scs_r;
reg [3:0] ircf_r;
reg spll_r;
reg [5:0] tune_r;
reg [1:0] fosc_lat_r;
reg [1:0] lat_cnt_r;
wire wr_en = psel & penable & pwrite;
assign pready = 1'b1;
assign pslverr = 1'b0;
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		scs_r <= `SCS_SEL_FOSC;
		ircf_r <= `SCS_IRCF_RST;
		spll_r <= 1'b0;
		tune_r <= 6'h00;
		fosc_lat_r <= `SCS_FOSC_INT;
		lat_cnt_r <= 2'h0;
	end
	else
	begin
		// Synchroniser is still in reset for two edges; latch only once it holds the pin
		if (lat_cnt_r != `SCS_LAT_END)
			lat_cnt_r <= lat_cnt_r + 2'h1;
		if (lat_cnt_r == `SCS_LAT_CYC)
			fosc_lat_r <= fosc_s_r;
		if (wr_en && paddr == `SCS_ADDR_CTRL)
		begin
			scs_r <= pwdata[1:0];
			ircf_r <= pwdata[`SCS_CTRL_IRCF_LSB+3:`SCS_CTRL_IRCF_LSB];
			spll_r <= pwdata[`SCS_CTRL_SPLL];
		end
		if (wr_en && paddr == `SCS_ADDR_TUNE)
			tune_r <= pwdata[5:0];
	end
end
// ****************************************
// Source enables and status
// ****************************************
wire int_sel = (fosc_lat_r == `SCS_FOSC_INT) | scs_r[1];
wire ircf_lf = (ircf_r == `SCS_IRCF_LF);
wire ircf_hf = (ircf_r >= `SCS_IRCF_HF_MIN);
wire pll_ok = (fosc_lat_r == `SCS_FOSC_INT) & (scs_r == `SCS_SEL_FOSC) &
	(ircf_r == `SCS_IRCF_PLL) & (spll_r | plc_s_r);
reg [15:0] hf_cnt_r;
reg hf_ready_flag;
reg hf_locked_flag;
reg hf_stable_flag;
reg mf_ready_flag;
reg lf_ready_flag;
reg hf_prev_r;
reg mf_prev_r;
reg lf_prev_r;
wire hf_edge = src_s_r[2] & ~hf_prev_r;
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		hf_enable <= 1'b0;
		mf_enable <= 1'b0;
		lf_enable <= 1'b0;
		pll_enable <= 1'b0;
		fast_start_en <= 1'b0;
		tune_out <= 6'h00;
		osc_startup_timer_en <= 1'b0;
		clock_input_pin_is_gpio <= 1'b1;
		hf_cnt_r <= 16'h0000;
		hf_ready_flag <= 1'b0;
		hf_locked_flag <= 1'b0;
		hf_stable_flag <= 1'b0;
		mf_ready_flag <= 1'b0;
		lf_ready_flag <= 1'b0;
		hf_prev_r <= 1'b0;
		mf_prev_r <= 1'b0;
		lf_prev_r <= 1'b0;
	end
	else
	begin
		hf_enable <= int_sel & ircf_hf;
		mf_enable <= int_sel & ~ircf_lf;
		lf_enable <= int_sel & ircf_lf;
		pll_enable <= pll_ok;
		tune_out <= tune_r;
		osc_startup_timer_en <= 1'b0;
		clock_input_pin_is_gpio <= (fosc_lat_r == `SCS_FOSC_INT);
		fast_start_en <= hf_enable & ~hf_stable_flag;
		hf_prev_r <= src_s_r[2];
		mf_prev_r <= src_s_r[3];
		lf_prev_r <= src_s_r[4];
		// Ready means an edge seen while enabled; tolerance is approximated by edge count
		if (!hf_enable)
			hf_cnt_r <= 16'h0000;
		else if (hf_edge && hf_cnt_r != 16'hFFFF)
			hf_cnt_r <= hf_cnt_r + 16'h0001;
		hf_ready_flag <= hf_enable & (hf_cnt_r != 16'h0000);
		hf_locked_flag <= hf_enable & (hf_cnt_r >= LOCK_CYC);
		hf_stable_flag <= hf_enable & (hf_cnt_r >= STABLE_CYC);
		if (!mf_enable)
			mf_ready_flag <= 1'b0;
		else if (src_s_r[3] & ~mf_prev_r)
			mf_ready_flag <= 1'b1;
		if (!lf_enable)
			lf_ready_flag <= 1'b0;
		else if (src_s_r[4] & ~lf_prev_r)
			lf_ready_flag <= 1'b1;
	end
end
// ****************************************
// Clock mux and output pin
// ****************************************
// Switch only while both old and new replicas are low: no runt pulse
reg [2:0] cur_src_r;
reg [2:0] want_src;
always @*
begin
	if (scs_r == `SCS_SEL_TMR)
		want_src = 3'h1;
	else if (scs_r[1] || fosc_lat_r == `SCS_FOSC_INT)
		want_src = ircf_lf ? 3'h4 : (ircf_hf ? 3'h2 : 3'h3);
	else
		want_src = 3'h0;
end
wire cur_lvl = src_s_r[cur_src_r];
wire new_lvl = src_s_r[want_src];
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		cur_src_r <= 3'h3;
		sysclk_out <= 1'b0;
		clock_output_pin <= 1'b0;
		clock_output_oe <= 1'b0;
	end
	else
	begin
		// Output already low one cycle, so the low phase spans at least two cycles
		if (want_src != cur_src_r && !sysclk_out && !cur_lvl && !new_lvl)
			cur_src_r <= want_src;
		sysclk_out <= cur_lvl;
		clock_output_pin <= sysclk_out;
		clock_output_oe <= ~coe_s_r;
	end
end
// ****************************************
// Read mux
// ****************************************
always @*
begin
	prdata = 32'h00000000;
	case (paddr)
	`SCS_ADDR_CTRL: prdata = {24'h000000, spll_r, ircf_r, 1'b0, scs_r};
	`SCS_ADDR_STAT: prdata = {25'h0000000, fosc_lat_r, lf_ready_flag, mf_ready_flag,
		hf_stable_flag, hf_locked_flag, hf_ready_flag};
	`SCS_ADDR_TUNE: prdata = {26'h0000000, tune_r};
	default: prdata = 32'h00000000;
	endcase
end
endmodule // scs_clock_select

//--- logic/scs_defs.vh
// Constants for the system clock source select block
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
`define SCS_ADDR_CTRL 12'h000
`define SCS_ADDR_STAT 12'h004
`define SCS_ADDR_TUNE 12'h008
`define SCS_FOSC_ECH 2'h3
`define SCS_FOSC_ECM 2'h2
`define SCS_FOSC_ECL 2'h1
`define SCS_FOSC_INT 2'h0
`define SCS_SEL_FOSC 2'h0
`define SCS_SEL_TMR 2'h1
`define SCS_IRCF_RST 4'h7
`define SCS_IRCF_PLL 4'hE
`define SCS_IRCF_LF 4'h0
`define SCS_IRCF_HF_MIN 4'hB
`define SCS_CTRL_IRCF_LSB 3
`define SCS_CTRL_SPLL 7
`define SCS_TUNE_W 6
`define SCS_LAT_CYC 2'h2
`define SCS_LAT_END 2'h3
`define SCS_LOCK_CYC 16'h0040
`define SCS_STABLE_CYC 16'h0100
`endif

//--- test/scs_ext_src.sv
// External logic-level clock source model
`timescale 1ns/1ps
module scs_ext_src (
	input logic run,
	output logic clk_pin
);
	initial clk_pin = 1'b0;
	// Stands low while stopped, never a stale level
	always #20 clk_pin = run ? ~clk_pin : 1'b0;
endmodule // scs_ext_src

//--- test/scs_checker.sv
// Port checker for the clock source select block
`timescale 1ns/1ps
module scs_checker #(
	parameter LOCK_CYC = 64,
	parameter STABLE_CYC = 256
) (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic pready,
	input logic pslverr,
	input logic [1:0] fosc_cfg,
	input logic clock_output_enable_n,
	input logic sysclk_out,
	input logic clock_output_pin,
	input logic clock_output_oe,
	input logic clock_input_pin_is_gpio,
	input logic pll_enable,
	input logic [5:0] tune_out,
	input logic osc_startup_timer_en
);
	// ****************
	// Assertions
	// ****************
	logic [2:0] up_r;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Counts settle time so the synced config has landed
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			up_r <= 3'h0;
		else if (up_r != 3'h7)
			up_r <= up_r + 3'h1;
	sequence hi2; sysclk_out [*2]; endsequence
	sequence lo2; !sysclk_out [*2]; endsequence
	ready_high_a: assert property (pready && !pslverr) else $error("bus answer wrong");
	no_ost_a: assert property (!osc_startup_timer_en) else $error("start timer on");
	oe_on_a: assert property (!clock_output_enable_n [*6] |-> clock_output_oe)
		else $error("clock out not enabled");
	oe_off_a: assert property (clock_output_enable_n [*6] |-> !clock_output_oe)
		else $error("clock out not disabled");
	gpio_cfg_a: assert property (up_r == 3'h7 |-> clock_input_pin_is_gpio == (fosc_cfg == 2'h0))
		else $error("input pin use wrong");
	pll_int_a: assert property (pll_enable |-> fosc_cfg == 2'h0) else $error("pll wrong");
	clock_output_pin_copy_a: assert property (clock_output_oe && $past(clock_output_oe)
		|-> clock_output_pin == $past(sysclk_out)) else $error("clock out copy wrong");
	tune_load_a: assert property (psel && penable && pwrite && paddr == 12'h008
		|=> ##1 tune_out == $past(pwdata[5:0], 2)) else $error("tune not loaded");
	no_runt_a: assert property ($rose(sysclk_out) |-> hi2) else $error("runt high");
	no_dip_a: assert property ($fell(sysclk_out) |-> lo2) else $error("runt low");
endmodule // scs_checker
bind scs_clock_select scs_checker #(.LOCK_CYC(LOCK_CYC), .STABLE_CYC(STABLE_CYC)) chk_u (.*);

//--- test/tb_system_clock_source_select.sv
// Testbench for the clock source select block
`timescale 1ns/1ps
module tb_system_clock_source_select;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_run, tmr_run;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] fosc_cfg;
	logic clock_output_enable_n, pll_cfg_en, clock_input_pin, timer_osc_clk;
	logic internal_16m_source, internal_500k_source, internal_31k_source;
	logic sysclk_out, clock_output_pin, clock_output_oe, clock_input_pin_is_gpio, hf_enable;
	logic mf_enable, lf_enable, pll_enable, fast_start_en, osc_startup_timer_en;
	logic [5:0] tune_out;
	int mismatches, check_count, n;
	// ****************
	// Sources and tasks
	// ****************
	scs_clock_select #(.LOCK_CYC(4), .STABLE_CYC(8)) dut_u (.*);
	scs_ext_src ext_u (.run(ext_run), .clk_pin(clock_input_pin));
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always #45 timer_osc_clk = tmr_run & ~timer_osc_clk;
	always #31 internal_16m_source = ~internal_16m_source;
	always #100 internal_500k_source = ~internal_500k_source;
	always #160 internal_31k_source = ~internal_31k_source;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rst(input logic [1:0] f);
		presetn <= 1'b0;
		fosc_cfg <= f;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask
	// Counts sysclk changes over a fixed span
	task automatic toggles();
		logic p;
		n = 0;
		p = sysclk_out;
		repeat (200)
		begin
			@(posedge pclk);
			#1;
			if (sysclk_out !== p) n++;
			p = sysclk_out;
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#100us;
		mismatches++;
		complete_run();
	end
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, presetn, fosc_cfg, pll_cfg_en} = '0;
		{timer_osc_clk, internal_16m_source, internal_500k_source, internal_31k_source} = '0;
		{clock_output_enable_n, ext_run, tmr_run} = 3'h6;
		for (int f = 0; f < 4; f++)
		begin
			rst(2'(f));
			xfer(1'b0, 12'h000, 32'h0);
			chk("ctrl", 32'h38, rd);
			xfer(1'b0, 12'h004, 32'h0);
			chk("src", 32'(f), {30'h0, rd[6:5]});
			chk("gpio", {31'h0, f == 0}, {31'h0, clock_input_pin_is_gpio});
		end
		$display("test src done");
		toggles();
		chk("ext run", 32'h1, {31'h0, n > 2});
		ext_run <= 1'b0;
		tmr_run <= 1'b1;
		repeat (20) @(posedge pclk);
		toggles();
		chk("ext stop", 32'h0, n);
		xfer(1'b1, 12'h000, 32'h39);
		toggles();
		chk("timer", 32'h1, {31'h0, n > 2});
		xfer(1'b1, 12'h000, 32'h3A);
		toggles();
		chk("internal", 32'h1, {31'h0, n > 2});
		xfer(1'b1, 12'h008, 32'h2A);
		xfer(1'b0, 12'h008, 32'h0);
		chk("tune", 32'h2A, rd);
		xfer(1'b0, 12'h00C, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("test switch done");
		rst(2'h0);
		xfer(1'b1, 12'h000, 32'h78);
		repeat (300) @(posedge pclk);
		xfer(1'b0, 12'h004, 32'h0);
		chk("hf flags", 32'h7, {29'h0, rd[2:0]});
		chk("hf en", 32'h1, {31'h0, hf_enable & ~pll_enable});
		xfer(1'b1, 12'h000, 32'hF0);
		repeat (20) @(posedge pclk);
		chk("pll", 32'h1, {31'h0, pll_enable});
		xfer(1'b1, 12'h000, 32'h38);
		clock_output_enable_n <= 1'b0;
		repeat (300) @(posedge pclk);
		xfer(1'b0, 12'h004, 32'h0);
		chk("mf", 32'h3, {30'h0, rd[3], mf_enable});
		chk("oe", 32'h1, {31'h0, clock_output_oe});
		$display("test internal done");
		complete_run();
	end
endmodule // tb_system_clock_source_select
